// *** vcp_regs.sv ***
`timescale 1ns/1ns
`default_nettype none

// Port VC control, status and resource-0 capability bank
module vcp_regs (
    // Clock and reset
    input  wire logic                           clk_sys_in,
    input  wire logic                           rst_n_in,

    // Port role strap, high on the upstream port
    input  wire logic                           port_upstream_strap_in,

    // AXI4-Lite write address
    input  wire logic [vcp_pkg::VCP_ADDR_W-1:0] s_axil_awaddr_in,
    input  wire logic [2:0]                     s_axil_awprot_in,
    input  wire logic                           s_axil_awvalid_in,
    output logic                                s_axil_awready_out,

    // AXI4-Lite write data
    input  wire logic [31:0]                    s_axil_wdata_in,
    input  wire logic [3:0]                     s_axil_wstrb_in,
    input  wire logic                           s_axil_wvalid_in,
    output logic                                s_axil_wready_out,

    // AXI4-Lite write response
    output logic [1:0]                          s_axil_bresp_out,
    output logic                                s_axil_bvalid_out,
    input  wire logic                           s_axil_bready_in,

    // AXI4-Lite read address
    input  wire logic [vcp_pkg::VCP_ADDR_W-1:0] s_axil_araddr_in,
    input  wire logic [2:0]                     s_axil_arprot_in,
    input  wire logic                           s_axil_arvalid_in,
    output logic                                s_axil_arready_out,

    // AXI4-Lite read data
    output logic [31:0]                         s_axil_rdata_out,
    output logic [1:0]                          s_axil_rresp_out,
    output logic                                s_axil_rvalid_out,
    input  wire logic                           s_axil_rready_in,

    // Captured port role
    output logic                                port_upstream_out,
    output logic                                role_valid_out
);

    import vcp_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic                  strap_sync;
    logic [1:0]            settle_q;
    logic [1:0]            settle_d;
    logic                  upstream_q;
    logic                  upstream_d;
    logic                  role_valid_q;
    logic                  role_valid_d;

    logic [31:0]           ctrl_word;
    logic [31:0]           stat_word;
    logic [31:0]           cap_word;
    logic [31:0]           cfg_word;
    logic [31:0]           bank_word;
    logic [7:0]            parb_cap;
    logic [7:0]            tbl_off;

    logic                  werr_en_q;
    logic                  werr_en_d;
    logic [7:0]            ign_cnt_q;
    logic [7:0]            ign_cnt_d;

    logic [VCP_ADDR_W-1:0] wr_addr;
    logic [31:0]           wr_data;
    logic [3:0]            wr_strb;
    logic                  wr_fire;
    logic [1:0]            wr_resp;
    logic                  wr_hit_ctrl;
    logic                  wr_hit_stat;
    logic                  wr_hit_cap;
    logic                  wr_hit_cfg;
    logic                  wr_hit_bank;
    logic                  wr_hit_ro;
    logic                  wr_mapped;
    logic                  cfg_wr;
    logic                  ign_wr;

    vcp_rd_state_t         rd_state_q;
    vcp_rd_state_t         rd_state_d;
    logic                  ar_take;
    logic                  r_done;
    logic                  rd_hit_ctrl;
    logic                  rd_hit_stat;
    logic                  rd_hit_cap;
    logic                  rd_hit_cfg;
    logic                  rd_hit_bank;
    logic                  rd_mapped;
    logic [31:0]           rd_word;
    logic [1:0]            rd_resp;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic [1:0]            rresp_q;
    logic [1:0]            rresp_d;

    // ----------------------------------------
    // Port role strap
    // ----------------------------------------

    // Strap is a pin, so it is synchronised before use
    vcp_sync #(
        .WIDTH (1)
    ) u_strap_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .async_in   (port_upstream_strap_in),
        .sync_out   (strap_sync)
    );

    // Role is latched once the synchroniser has filled
    assign settle_d     = (settle_q == VCP_STRAP_SETTLE) ? settle_q : settle_q + 2'h1;
    assign role_valid_d = role_valid_q || (settle_q == VCP_STRAP_SETTLE);
    assign upstream_d   = role_valid_q ? upstream_q : strap_sync;

    // Role registers; a later strap change is ignored
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle_q     <= 2'h0;
            role_valid_q <= 1'b0;
            upstream_q   <= 1'b0;
        end else begin
            settle_q     <= settle_d;
            role_valid_q <= role_valid_d;
            upstream_q   <= upstream_d;
        end
    end

    // ----------------------------------------
    // Fixed register contents
    // ----------------------------------------

    // Role-dependent values; downstream until the role is known
    assign parb_cap = upstream_q ? VCP_PARB_CAP_UP : VCP_PARB_CAP_DN;
    assign tbl_off  = upstream_q ? VCP_TBL_OFF_UP : VCP_TBL_OFF_DN;

    // Port VC control word, reserved bits zero
    always_comb begin
        ctrl_word = VCP_RST_WORD;
        ctrl_word[VCP_LOAD_TBL_BIT] = VCP_LOAD_TBL_VAL;
        ctrl_word[VCP_ARB_SEL_LSB +: VCP_ARB_SEL_W] = VCP_ARB_SEL_VAL;
    end

    // Port VC status word, reserved bits zero
    always_comb begin
        stat_word = VCP_RST_WORD;
        stat_word[VCP_TBL_STS_BIT] = VCP_TBL_STS_VAL;
    end

    // Resource-0 capability word, one scheme per capability bit
    always_comb begin
        cap_word = VCP_RST_WORD;
        cap_word[VCP_PARB_CAP_LSB +: VCP_PARB_CAP_W] = parb_cap;
        cap_word[VCP_ADV_PS_BIT] = VCP_ADV_PS_VAL;
        cap_word[VCP_REJ_SNOOP_BIT] = VCP_REJ_SNOOP_VAL;
        cap_word[VCP_MAX_TS_LSB +: VCP_MAX_TS_W] = VCP_MAX_TS_VAL;
        cap_word[VCP_TBL_OFF_LSB +: VCP_TBL_OFF_W] = tbl_off;
    end

    // ----------------------------------------
    // Bank configuration and status
    // ----------------------------------------

    // Config: error-on-ignored-write enable
    always_comb begin
        cfg_word = VCP_RST_WORD;
        cfg_word[VCP_CFG_WERR_BIT] = werr_en_q;
    end

    // Status: role, role valid, ignored-write count
    always_comb begin
        bank_word = VCP_RST_WORD;
        bank_word[VCP_STS_UP_BIT] = upstream_q;
        bank_word[VCP_STS_VALID_BIT] = role_valid_q;
        bank_word[VCP_STS_CNT_LSB +: VCP_IGN_CNT_W] = ign_cnt_q;
    end

    // ----------------------------------------
    // Write path
    // ----------------------------------------

    // Write channel handshakes live in their own module
    vcp_axil_wr u_wr (
        .clk_sys_in  (clk_sys_in),
        .rst_n_in    (rst_n_in),
        .awaddr_in   (s_axil_awaddr_in),
        .awvalid_in  (s_axil_awvalid_in),
        .awready_out (s_axil_awready_out),
        .wdata_in    (s_axil_wdata_in),
        .wstrb_in    (s_axil_wstrb_in),
        .wvalid_in   (s_axil_wvalid_in),
        .wready_out  (s_axil_wready_out),
        .bresp_out   (s_axil_bresp_out),
        .bvalid_out  (s_axil_bvalid_out),
        .bready_in   (s_axil_bready_in),
        .resp_in     (wr_resp),
        .wr_addr_out (wr_addr),
        .wr_data_out (wr_data),
        .wr_strb_out (wr_strb),
        .wr_fire_out (wr_fire)
    );

    // Write decode on word address; low two bits ignored
    assign wr_hit_ctrl = (wr_addr[11:2] == VCP_IDX_PORT_VC_CONTROL);
    assign wr_hit_stat = (wr_addr[11:2] == VCP_IDX_PORT_VC_STATUS);
    assign wr_hit_cap  = (wr_addr[11:2] == VCP_IDX_VC_RES0_CAP);
    assign wr_hit_cfg  = (wr_addr[11:2] == VCP_IDX_BANK_CONFIG);
    assign wr_hit_bank = (wr_addr[11:2] == VCP_IDX_BANK_STATUS);
    assign wr_hit_ro   = wr_hit_ctrl || wr_hit_stat || wr_hit_cap;
    assign wr_mapped   = wr_hit_ro || wr_hit_cfg || wr_hit_bank;

    // Writes into the fixed words store nothing, only counted
    assign ign_wr = wr_fire && wr_hit_ro;
    assign cfg_wr = wr_fire && wr_hit_cfg && wr_strb[0];

    // Response: decode error off map, optional error on fixed words
    assign wr_resp = !wr_mapped ? VCP_RESP_DECERR :
                     (wr_hit_ro && werr_en_q) ? VCP_RESP_SLVERR :
                     VCP_RESP_OKAY;

    // Next config and counter values; counter saturates, never wraps
    assign werr_en_d = cfg_wr ? wr_data[VCP_CFG_WERR_BIT] : werr_en_q;
    assign ign_cnt_d = (ign_wr && (ign_cnt_q != 8'hFF)) ? ign_cnt_q + 8'h01 : ign_cnt_q;

    // Config and counter registers
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            werr_en_q <= VCP_RST_WERR;
            ign_cnt_q <= VCP_RST_IGN_CNT;
        end else begin
            werr_en_q <= werr_en_d;
            ign_cnt_q <= ign_cnt_d;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------

    // Handshake terms
    assign ar_take = s_axil_arvalid_in && s_axil_arready_out;
    assign r_done  = s_axil_rvalid_out && s_axil_rready_in;

    // Read decode straight from the offered address
    assign rd_hit_ctrl = (s_axil_araddr_in[11:2] == VCP_IDX_PORT_VC_CONTROL);
    assign rd_hit_stat = (s_axil_araddr_in[11:2] == VCP_IDX_PORT_VC_STATUS);
    assign rd_hit_cap  = (s_axil_araddr_in[11:2] == VCP_IDX_VC_RES0_CAP);
    assign rd_hit_cfg  = (s_axil_araddr_in[11:2] == VCP_IDX_BANK_CONFIG);
    assign rd_hit_bank = (s_axil_araddr_in[11:2] == VCP_IDX_BANK_STATUS);
    assign rd_mapped   = rd_hit_ctrl || rd_hit_stat || rd_hit_cap || rd_hit_cfg || rd_hit_bank;

    // Read data select; off-map reads return zero
    assign rd_word = rd_hit_ctrl ? ctrl_word :
                     rd_hit_stat ? stat_word :
                     rd_hit_cap  ? cap_word :
                     rd_hit_cfg  ? cfg_word :
                     rd_hit_bank ? bank_word :
                     VCP_RST_WORD;
    assign rd_resp = rd_mapped ? VCP_RESP_OKAY : VCP_RESP_DECERR;

    // Data and response latch at acceptance, held while waiting
    assign rdata_d = ar_take ? rd_word : rdata_q;
    assign rresp_d = ar_take ? rd_resp : rresp_q;

    // Read sequencer: one read in flight
    always_comb begin
        rd_state_d = rd_state_q;
        case (rd_state_q)
            VCP_RD_IDLE: begin
                if (ar_take) begin
                    rd_state_d = VCP_RD_RESP;
                end
            end
            VCP_RD_RESP: begin
                if (r_done) begin
                    rd_state_d = VCP_RD_IDLE;
                end
            end
            default: begin
                rd_state_d = VCP_RD_IDLE;
            end
        endcase
    end

    // Read registers; ready and valid decoded from next state
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_state_q         <= VCP_RD_IDLE;
            rdata_q            <= VCP_RST_WORD;
            rresp_q            <= VCP_RESP_OKAY;
            s_axil_arready_out <= 1'b1;
            s_axil_rvalid_out  <= 1'b0;
        end else begin
            rd_state_q         <= rd_state_d;
            rdata_q            <= rdata_d;
            rresp_q            <= rresp_d;
            s_axil_arready_out <= (rd_state_d == VCP_RD_IDLE);
            s_axil_rvalid_out  <= (rd_state_d == VCP_RD_RESP);
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // Protection bits carry no meaning for this bank
    assign s_axil_rdata_out  = rdata_q;
    assign s_axil_rresp_out  = rresp_q;
    assign port_upstream_out = upstream_q;
    assign role_valid_out    = role_valid_q;

endmodule // vcp_regs

`default_nettype wire

// *** vcp_pkg.sv ***
// Contract
// - Load VC table bit reads zero, no effect
// - VC arbitration select reads fixed zero
// - VC arbitration table status always reads zero
// - Capability 0x3 upstream, 0x1 downstream
// - One capability bit per arbitration scheme
// - Table offset 0x2 upstream, 0x0 downstream
// - Advanced packet switching bit reads zero
// - Reject snoop bit reads zero
// - Maximum time slots field reads zero
`default_nettype none

package vcp_pkg;

    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int unsigned VCP_ADDR_W = 12;
    localparam int unsigned VCP_DATA_W = 32;

    // ----------------------------------------
    // Register indices and byte addresses
    // ----------------------------------------
    localparam logic [9:0]  VCP_IDX_PORT_VC_CONTROL = 10'h20C;
    localparam logic [9:0]  VCP_IDX_PORT_VC_STATUS  = 10'h20E;
    localparam logic [9:0]  VCP_IDX_VC_RES0_CAP     = 10'h210;
    localparam logic [9:0]  VCP_IDX_BANK_CONFIG     = 10'h211;
    localparam logic [9:0]  VCP_IDX_BANK_STATUS     = 10'h212;
    localparam logic [11:0] VCP_ADDR_PORT_VC_CONTROL = {VCP_IDX_PORT_VC_CONTROL, 2'b00};
    localparam logic [11:0] VCP_ADDR_PORT_VC_STATUS  = {VCP_IDX_PORT_VC_STATUS, 2'b00};
    localparam logic [11:0] VCP_ADDR_VC_RES0_CAP     = {VCP_IDX_VC_RES0_CAP, 2'b00};
    localparam logic [11:0] VCP_ADDR_BANK_CONFIG     = {VCP_IDX_BANK_CONFIG, 2'b00};
    localparam logic [11:0] VCP_ADDR_BANK_STATUS     = {VCP_IDX_BANK_STATUS, 2'b00};

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int unsigned VCP_LOAD_TBL_BIT  = 0;
    localparam int unsigned VCP_ARB_SEL_LSB   = 1;
    localparam int unsigned VCP_ARB_SEL_W     = 3;
    localparam int unsigned VCP_TBL_STS_BIT   = 0;
    localparam int unsigned VCP_PARB_CAP_LSB  = 0;
    localparam int unsigned VCP_PARB_CAP_W    = 8;
    localparam int unsigned VCP_ADV_PS_BIT    = 14;
    localparam int unsigned VCP_REJ_SNOOP_BIT = 15;
    localparam int unsigned VCP_MAX_TS_LSB    = 16;
    localparam int unsigned VCP_MAX_TS_W      = 7;
    localparam int unsigned VCP_TBL_OFF_LSB   = 24;
    localparam int unsigned VCP_TBL_OFF_W     = 8;
    localparam int unsigned VCP_CFG_WERR_BIT  = 0;
    localparam int unsigned VCP_STS_UP_BIT    = 0;
    localparam int unsigned VCP_STS_VALID_BIT = 1;
    localparam int unsigned VCP_STS_CNT_LSB   = 8;
    localparam int unsigned VCP_IGN_CNT_W     = 8;

    // ----------------------------------------
    // Field values
    // ----------------------------------------
    localparam logic       VCP_LOAD_TBL_VAL   = 1'b0;
    localparam logic [2:0] VCP_ARB_SEL_VAL    = 3'h0;
    localparam logic       VCP_TBL_STS_VAL    = 1'b0;
    localparam logic [7:0] VCP_PARB_CAP_UP    = 8'h03;
    localparam logic [7:0] VCP_PARB_CAP_DN    = 8'h01;
    localparam logic       VCP_ADV_PS_VAL     = 1'b0;
    localparam logic       VCP_REJ_SNOOP_VAL  = 1'b0;
    localparam logic [6:0] VCP_MAX_TS_VAL     = 7'h00;
    localparam logic [7:0] VCP_TBL_OFF_UP     = 8'h02;
    localparam logic [7:0] VCP_TBL_OFF_DN     = 8'h00;

    // ----------------------------------------
    // Reset values, counts, responses
    // ----------------------------------------
    localparam logic [31:0] VCP_RST_WORD       = 32'h0000_0000;
    localparam logic        VCP_RST_WERR       = 1'b0;
    localparam logic [7:0]  VCP_RST_IGN_CNT    = 8'h00;
    localparam logic [1:0]  VCP_STRAP_SETTLE   = 2'h2;
    localparam logic [1:0]  VCP_RESP_OKAY      = 2'h0;
    localparam logic [1:0]  VCP_RESP_SLVERR    = 2'h2;
    localparam logic [1:0]  VCP_RESP_DECERR    = 2'h3;

    // Read channel states
    typedef enum logic [0:0] {
        VCP_RD_IDLE,
        VCP_RD_RESP
    } vcp_rd_state_t;

endpackage : vcp_pkg

`default_nettype wire

// *** vcp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for slow level inputs
module vcp_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // vcp_sync

`default_nettype wire

// *** vcp_axil_wr.sv ***
`timescale 1ns/1ns
`default_nettype none

// AXI4-Lite write channel: address and data in any order
module vcp_axil_wr
    import vcp_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_n_in,
    // Write address and data
    input  wire logic [VCP_ADDR_W-1:0] awaddr_in,
    input  wire logic                  awvalid_in,
    output logic                       awready_out,
    input  wire logic [31:0]           wdata_in,
    input  wire logic [3:0]            wstrb_in,
    input  wire logic                  wvalid_in,
    output logic                       wready_out,
    // Write response
    output logic [1:0]                 bresp_out,
    output logic                       bvalid_out,
    input  wire logic                  bready_in,
    // Toward the register file
    input  wire logic [1:0]            resp_in,
    output logic [VCP_ADDR_W-1:0]      wr_addr_out,
    output logic [31:0]                wr_data_out,
    output logic [3:0]                 wr_strb_out,
    output logic                       wr_fire_out
);

    logic aw_take;
    logic w_take;
    logic fire;

    // One write in flight: both halves held until response taken
    assign aw_take = awvalid_in && awready_out;
    assign w_take  = wvalid_in && wready_out;
    assign fire    = !awready_out && !wready_out && !bvalid_out && !wr_fire_out;

    // Capture halves, then answer two cycles after both are held
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            awready_out <= 1'b1;
            wready_out  <= 1'b1;
            bvalid_out  <= 1'b0;
            bresp_out   <= VCP_RESP_OKAY;
            wr_addr_out <= '0;
            wr_data_out <= VCP_RST_WORD;
            wr_strb_out <= 4'h0;
            wr_fire_out <= 1'b0;
        end else begin
            wr_fire_out <= fire;
            if (aw_take) begin
                awready_out <= 1'b0;
                wr_addr_out <= awaddr_in;
            end
            if (w_take) begin
                wready_out  <= 1'b0;
                wr_data_out <= wdata_in;
                wr_strb_out <= wstrb_in;
            end
            if (wr_fire_out) begin
                bvalid_out <= 1'b1;
                bresp_out  <= resp_in;
            end else if (bvalid_out && bready_in) begin
                bvalid_out  <= 1'b0;
                awready_out <= 1'b1;
                wready_out  <= 1'b1;
            end
        end
    end

endmodule // vcp_axil_wr

`default_nettype wire

// *** vcp_regs_chk_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Read-back checks on the fixed VC words, plus the latched role hold
// ----------------------------------------
module vcp_regs_chk
    import vcp_pkg::*;
(
    // Clock and reset
    input wire logic                  clk_sys_in,
    input wire logic                  rst_n_in,
    // Read channel
    input wire logic [VCP_ADDR_W-1:0] s_axil_araddr_in,
    input wire logic                  s_axil_arvalid_in,
    input wire logic                  s_axil_arready_out,
    input wire logic [31:0]           s_axil_rdata_out,
    input wire logic [1:0]            s_axil_rresp_out,
    input wire logic                  s_axil_rvalid_out,
    // Latched role
    input wire logic                  port_upstream_out,
    input wire logic                  role_valid_out
);
    // One domain, reset drops every check
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    // Read taken at one word
    sequence s_take(logic [9:0] idx);
        s_axil_arvalid_in && s_axil_arready_out && (s_axil_araddr_in[11:2] == idx);
    endsequence
    // Answer on the next edge, okay and with a given word
    sequence s_word(logic [31:0] val);
        s_axil_rvalid_out && (s_axil_rdata_out == val) && (s_axil_rresp_out == VCP_RESP_OKAY);
    endsequence

    AST_CTRL_ZERO: assert property (s_take(VCP_IDX_PORT_VC_CONTROL) |=> s_word(32'h0000_0000))
        else $error("control word not zero");
    AST_STS_ZERO: assert property (s_take(VCP_IDX_PORT_VC_STATUS) |=> s_word(32'h0000_0000))
        else $error("status word not zero");
    AST_CAP_UP: assert property (s_take(VCP_IDX_VC_RES0_CAP) ##0 (role_valid_out && port_upstream_out)
        |=> s_word(32'h0200_0003)) else $error("upstream capability word wrong");
    AST_CAP_DN: assert property (s_take(VCP_IDX_VC_RES0_CAP) ##0 !port_upstream_out
        |=> s_word(32'h0000_0001)) else $error("downstream capability word wrong");
    AST_CAP_SCHEMES: assert property (s_take(VCP_IDX_VC_RES0_CAP) |=> (s_axil_rdata_out[7:2] == 6'h00)
        && (s_axil_rdata_out[0] == 1'b1)) else $error("unsupported scheme bit set");
    AST_CAP_APS_REJECT_SNOOP: assert property (s_take(VCP_IDX_VC_RES0_CAP) |=> s_axil_rdata_out[15:14] == 2'h0)
        else $error("switching or snoop bit set");
    AST_CAP_MAX_TIME_SLOTS: assert property (s_take(VCP_IDX_VC_RES0_CAP) |=> s_axil_rdata_out[22:16] == 7'h00)
        else $error("time slot field not zero");
    // Role frozen once latched, a strap wobble must not move it
    AST_ROLE_HOLD: assert property (role_valid_out |=> role_valid_out && $stable(port_upstream_out))
        else $error("latched role moved");
endmodule // vcp_regs_chk

`default_nettype wire

// *** vcp_regs_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Bench for the fixed VC register bank
// ----------------------------------------
module vcp_regs_tb;
    import vcp_pkg::*;
    // Bench names match the ports so the instance wires up by name
    logic        clk_sys_in, rst_n_in, port_upstream_strap_in;
    logic [11:0] s_axil_awaddr_in, s_axil_araddr_in;
    logic [2:0]  s_axil_awprot_in, s_axil_arprot_in;
    logic [31:0] s_axil_wdata_in, s_axil_rdata_out, d;
    logic [3:0]  s_axil_wstrb_in;
    logic [1:0]  s_axil_bresp_out, s_axil_rresp_out, r;
    logic        s_axil_awvalid_in, s_axil_wvalid_in, s_axil_bready_in, s_axil_arvalid_in, s_axil_rready_in;
    logic        s_axil_awready_out, s_axil_wready_out, s_axil_bvalid_out, s_axil_arready_out, s_axil_rvalid_out;
    logic        port_upstream_out, role_valid_out;
    int          n_mismatch, n_checks;

    vcp_regs u_vcp_regs (.*);

    // 10 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    // ----------------------------------------
    // Verdict and comparison
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // A wait that runs dry ends the run
    task automatic hang();
        n_mismatch++;
        $display("MISMATCH t=%0t got %h exp %h", $time, 1'b0, 1'b1);
        final_report();
    endtask

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Both write channels offered together, each dropped once taken
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] br);
        int i;
        @(posedge clk_sys_in);
        s_axil_awaddr_in <= a;
        s_axil_wdata_in <= wd;
        s_axil_awvalid_in <= 1'b1;
        s_axil_wvalid_in <= 1'b1;
        s_axil_bready_in <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clk_sys_in);
            if (s_axil_awvalid_in && s_axil_awready_out === 1'b1) s_axil_awvalid_in <= 1'b0;
            if (s_axil_wvalid_in && s_axil_wready_out === 1'b1) s_axil_wvalid_in <= 1'b0;
            if (s_axil_bvalid_out === 1'b1) break;
        end
        if (i == 40) hang();
        br = s_axil_bresp_out;
        s_axil_bready_in <= 1'b0;
    endtask
    task automatic bus_rd(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rr);
        int i;
        @(posedge clk_sys_in);
        s_axil_araddr_in <= a;
        s_axil_arvalid_in <= 1'b1;
        s_axil_rready_in <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clk_sys_in);
            if (s_axil_arvalid_in && s_axil_arready_out === 1'b1) s_axil_arvalid_in <= 1'b0;
            if (s_axil_rvalid_out === 1'b1) break;
        end
        if (i == 40) hang();
        rd = s_axil_rdata_out;
        rr = s_axil_rresp_out;
        s_axil_rready_in <= 1'b0;
    endtask
    // Strap held steady through reset, then wait for the role to latch
    task automatic do_reset(input logic up);
        int i;
        rst_n_in <= 1'b0;
        port_upstream_strap_in <= up;
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys_in);
            if (role_valid_out === 1'b1) break;
        end
        if (i == 20) hang();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Downstream port: each word read, hammered with ones, read again
    task automatic t_down();
        logic [11:0] adr [3];
        logic [31:0] exp [3];
        adr = '{VCP_ADDR_PORT_VC_CONTROL, VCP_ADDR_PORT_VC_STATUS, VCP_ADDR_VC_RES0_CAP};
        exp = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0001};
        for (int k = 0; k < 3; k++) begin
            bus_rd(adr[k], d, r);
            check(d, exp[k]);
            bus_wr(adr[k], 32'hFFFF_FFFF, r);
            check(32'(r), 32'(VCP_RESP_OKAY));
            bus_rd(adr[k], d, r);
            check(d, exp[k]);
        end
        check({23'h000000, d[22:14]}, 32'h0000_0000);
    endtask
    // Error reporting on, ignored-write count, unmapped place
    task automatic t_err();
        bus_wr(VCP_ADDR_BANK_CONFIG, 32'h0000_0001, r);
        bus_wr(VCP_ADDR_PORT_VC_STATUS, 32'hFFFF_FFFF, r);
        check(32'(r), 32'(VCP_RESP_SLVERR));
        bus_rd(VCP_ADDR_BANK_STATUS, d, r);
        check(d, 32'h0000_0402);
        bus_wr(12'hFFC, 32'h0000_0000, r);
        check(32'(r), 32'(VCP_RESP_DECERR));
        bus_rd(12'hFFC, d, r);
        check({d[29:0], r}, 32'(VCP_RESP_DECERR));
    endtask
    // Upstream port after a second reset; strap moves after the latch
    task automatic t_up();
        do_reset(1'b1);
        bus_rd(VCP_ADDR_VC_RES0_CAP, d, r);
        check(d, 32'h0200_0003);
        check({26'h0000000, d[5:0]}, 32'h0000_0003);
        bus_wr(VCP_ADDR_VC_RES0_CAP, 32'h0000_0000, r);
        check(32'(r), 32'(VCP_RESP_OKAY));
        port_upstream_strap_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        check(32'(port_upstream_out), 32'h0000_0001);
        bus_rd(VCP_ADDR_VC_RES0_CAP, d, r);
        check(d, 32'h0200_0003);
        bus_rd(VCP_ADDR_PORT_VC_STATUS, d, r);
        check(d, 32'h0000_0000);
    endtask

    // Main sequence; prot lines and strobes stay fixed
    initial begin
        n_mismatch = 0;
        n_checks = 0;
        {rst_n_in, port_upstream_strap_in, s_axil_awaddr_in, s_axil_araddr_in} = '0;
        {s_axil_awprot_in, s_axil_arprot_in, s_axil_wdata_in} = '0;
        {s_axil_awvalid_in, s_axil_wvalid_in, s_axil_bready_in, s_axil_arvalid_in, s_axil_rready_in} = '0;
        s_axil_wstrb_in = 4'hF;
        do_reset(1'b0);
        t_down();
        t_err();
        t_up();
        final_report();
    end
endmodule // vcp_regs_tb

bind vcp_regs vcp_regs_chk u_vcp_regs_chk (.*);

`default_nettype wire
